// >>> hdl/bus_router_pkg.sv
// Package with register map, source codes and sample carriers for the output bus router.
`default_nettype none
package bus_router_pkg;
   localparam int SAMPLE_W = 24;
   localparam int ATT_W = 6;
   localparam int GAIN_FRAC_W = 16;
   localparam logic [ATT_W-1:0] ATT_MAX_DB = 6'h28; // Forty one-decibel steps.
   localparam logic [ATT_W-1:0] ATT_STEP_DB = 6'h01;
   // Register byte offsets on the APB.
   localparam logic [7:0] ANA_SRC_OFS = 8'h00;
   localparam logic [7:0] DIG_SRC_OFS = 8'h04;
   localparam logic [7:0] HP_SRC_OFS = 8'h08;
   localparam logic [7:0] ANA_ATT_OFS = 8'h0c;
   localparam logic [7:0] DIG_ATT_OFS = 8'h10;
   localparam logic [7:0] FORMAT_OFS = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   // Field positions and reset values.
   localparam int SRC_L_LSB = 0;
   localparam int SRC_R_LSB = 4;
   localparam int FMT_PRO_BIT = 0;
   localparam int CS_PRO_BIT = 0;
   localparam int CS_COPY_BIT = 2;
   localparam logic [7:0] CS_RESET = 8'h00;
   localparam int PIPE_LAT = 3;
   typedef enum logic [2:0] {
      SRC_IN1 = 3'b000,
      SRC_IN2 = 3'b001,
      SRC_TRK_A = 3'b010,
      SRC_TRK_B = 3'b011,
      SRC_SUM_IN = 3'b100,
      SRC_SUM_TRK = 3'b101,
      SRC_MON_A = 3'b110,
      SRC_MON_B = 3'b111
   } src_t;
   typedef struct packed {
      src_t r;
      src_t l;
   } src_pair_t;
   typedef struct packed {
      logic signed [SAMPLE_W-1:0] r;
      logic signed [SAMPLE_W-1:0] l;
   } stereo_t;
   localparam src_pair_t SRC_RESET = '{r: SRC_IN2, l: SRC_IN1};
endpackage
`default_nettype wire

// >>> hdl/db_atten.sv
// Two-channel stepped attenuator sharing one decibel setting.
`default_nettype none
module db_atten
   import bus_router_pkg::*;
#(
   parameter int W = SAMPLE_W
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Setting and samples.
   input wire logic [ATT_W-1:0] att_db,
   input wire logic in_valid,
   input wire stereo_t in_s,
   output stereo_t out_s,
   output logic out_valid
);
   // Elaboration-time check: the gain table and carrier assume the package sample width.
   if (W != SAMPLE_W) begin
      $error("db_atten width must match the sample carrier");
   end

   // Six-decibel steps are a shift; the remainder comes from a small gain table.
   function automatic logic signed [W-1:0] scale(logic signed [W-1:0] x, logic [ATT_W-1:0] db);
      logic [ATT_W-1:0] q;
      logic [ATT_W-1:0] r;
      logic [GAIN_FRAC_W:0] g;
      logic signed [W+GAIN_FRAC_W+1:0] p;
      q = db / 6'h06;
      r = db - 6'(q * 6'h06);
      case (r)
         6'h00: g = 17'h10000;
         6'h01: g = 17'h0e429;
         6'h02: g = 17'h0cb59;
         6'h03: g = 17'h0b53c;
         6'h04: g = 17'h0a186;
         default: g = 17'h08ff6;
      endcase
      p = x * $signed({1'b0, g});
      p = p >>> (GAIN_FRAC_W + int'(q));
      return p[W-1:0];
   endfunction

   // One setting scales both channels alike.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_s <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_s.l <= scale(in_s.l, att_db);
            out_s.r <= scale(in_s.r, att_db);
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/audio_output_bus_router.sv
// Output bus router: source selection, summing, attenuation and APB registers.
//
// Summary of operation
// - Two stereo buses, analog and digital, keep independent source selections.
// - Left and right of each bus pick their own source.
// - An input source passes regardless of record or playback state.
// - Track source gives assigned audio while recording, recorded audio in playback.
// - Summed-inputs source outputs input one plus input two.
// - Summed-tracks source outputs track A plus track B audio.
// - Analog bus attenuates zero to forty decibels in one-decibel steps.
// - One analog attenuation setting acts equally on left and right.
// - Analog attenuation also applies to the consumer tape feed.
// - Digital bus selections never disturb analog or headphone selections.
// - Digital bus offers the same source set as the analog bus.
// - Digital stream channel status is professional or consumer by setting.
// - Copy management indication stays cleared in both formats.
// - Digital output peaks at full scale, attenuates to forty decibels down.
// - Headphone sources are chosen independently of both buses.
// - Track monitor while recording plays media readback, lagging up to twelve seconds.
// - Monitor audio while recording is read from the highlighted storage medium; in playback it is the recorded track audio.
//
// The register addresses and register access over APB were left to the implementer.
`default_nettype none
module audio_output_bus_router
   import bus_router_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sample sources, all aligned to sample_valid.
   input wire logic sample_valid,
   input wire stereo_t inputs,
   input wire stereo_t trk_assigned,
   input wire stereo_t trk_played,
   input wire stereo_t media0_read,
   input wire stereo_t media1_read,
   // Transport state and highlighted medium.
   input wire logic recording,
   input wire logic playing,
   input wire logic media_sel,
   // Outputs.
   output stereo_t line_out,
   output stereo_t tape_out,
   output stereo_t dig_out,
   output stereo_t hp_out,
   output logic out_valid,
   output logic [7:0] cs_byte
);
   localparam logic signed [SAMPLE_W-1:0] FS_POS = {1'b0, {(SAMPLE_W-1){1'b1}}};
   localparam logic signed [SAMPLE_W-1:0] FS_NEG = {1'b1, {(SAMPLE_W-1){1'b0}}};

   src_pair_t ana_src_ff;
   src_pair_t dig_src_ff;
   src_pair_t hp_src_ff;
   logic [ATT_W-1:0] ana_att_ff;
   logic [ATT_W-1:0] dig_att_ff;
   logic fmt_pro_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   stereo_t stage_ana_ff;
   stereo_t stage_dig_ff;
   stereo_t stage_hp_ff;
   stereo_t hp_dly_ff;
   logic stage_valid_ff;
   stereo_t ana_att_s;
   stereo_t dig_att_s;
   logic att_valid;
   stereo_t line_ff;
   stereo_t tape_ff;
   stereo_t dig_ff;
   stereo_t hp_ff;
   logic out_valid_ff;
   logic [7:0] cs_byte_ff;
   stereo_t trk_now;
   stereo_t mon_now;
   logic setup;
   logic [31:0] nxt_prdata;
   logic nxt_pslverr;

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Saturating add; a wrapped sum would turn a loud peak into a full-scale click.
   function automatic logic signed [SAMPLE_W-1:0] sat_sum(logic signed [SAMPLE_W-1:0] a,
                                                          logic signed [SAMPLE_W-1:0] b);
      logic signed [SAMPLE_W:0] s;
      s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
      if (s > $signed({1'b0, FS_POS})) return FS_POS;
      if (s < $signed({1'b1, FS_NEG})) return FS_NEG;
      return s[SAMPLE_W-1:0];
   endfunction

   // One source table serves every bus side, so the choices are identical.
   function automatic logic signed [SAMPLE_W-1:0] pick(src_t s);
      case (s)
         SRC_IN1: return inputs.l;
         SRC_IN2: return inputs.r;
         SRC_TRK_A: return trk_now.l;
         SRC_TRK_B: return trk_now.r;
         SRC_SUM_IN: return sat_sum(inputs.l, inputs.r);
         SRC_SUM_TRK: return sat_sum(trk_now.l, trk_now.r);
         SRC_MON_A: return mon_now.l;
         SRC_MON_B: return mon_now.r;
         default: return '0;
      endcase
   endfunction

   // Larger settings are held at the deepest step rather than refused.
   function automatic logic [ATT_W-1:0] clamp_att(logic [31:0] d);
      if (d[ATT_W-1:0] > ATT_MAX_DB || d[31:ATT_W] != '0) return ATT_MAX_DB;
      return d[ATT_W-1:0];
   endfunction

   function automatic logic [31:0] src_word(src_pair_t p);
      return 32'({1'b0, p.r, 1'b0, p.l});
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Track and monitor sources follow the transport.

   // Playback wins when both flags are high; recorded audio is what exists then.
   always_comb begin
      trk_now = playing ? trk_played : trk_assigned;
      if (playing) begin
         mon_now = trk_played;
      end else if (recording) begin
         mon_now = media_sel ? media1_read : media0_read;
      end else begin
         mon_now = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped addresses.

   assign setup = psel && !penable;

   // Read data is prepared in the setup cycle so prdata leaves a flip-flop.
   always_comb begin
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h00000000;
      case (paddr)
         ANA_SRC_OFS: nxt_prdata = src_word(ana_src_ff);
         DIG_SRC_OFS: nxt_prdata = src_word(dig_src_ff);
         HP_SRC_OFS: nxt_prdata = src_word(hp_src_ff);
         ANA_ATT_OFS: nxt_prdata = 32'(ana_att_ff);
         DIG_ATT_OFS: nxt_prdata = 32'(dig_att_ff);
         FORMAT_OFS: nxt_prdata = 32'(fmt_pro_ff);
         STATUS_OFS: nxt_prdata = 32'({media_sel, playing, recording});
         default: nxt_pslverr = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (setup) begin
            prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
         end
      end
   end

   // Each bus keeps its own selection register; a write touches only one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ana_src_ff <= SRC_RESET;
         dig_src_ff <= SRC_RESET;
         hp_src_ff <= SRC_RESET;
      end else if (psel && penable && pwrite) begin
         case (paddr)
            ANA_SRC_OFS: ana_src_ff <= {src_t'(pwdata[SRC_R_LSB +: 3]),
                                        src_t'(pwdata[SRC_L_LSB +: 3])};
            DIG_SRC_OFS: dig_src_ff <= {src_t'(pwdata[SRC_R_LSB +: 3]),
                                        src_t'(pwdata[SRC_L_LSB +: 3])};
            HP_SRC_OFS: hp_src_ff <= {src_t'(pwdata[SRC_R_LSB +: 3]),
                                      src_t'(pwdata[SRC_L_LSB +: 3])};
            default: ;
         endcase
      end
   end

   // Attenuation and format settings.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ana_att_ff <= '0;
         dig_att_ff <= '0;
         fmt_pro_ff <= 1'b0;
      end else if (psel && penable && pwrite) begin
         case (paddr)
            ANA_ATT_OFS: ana_att_ff <= clamp_att(pwdata);
            DIG_ATT_OFS: dig_att_ff <= clamp_att(pwdata);
            FORMAT_OFS: fmt_pro_ff <= pwdata[FMT_PRO_BIT];
            default: ;
         endcase
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Sample pipeline: select, attenuate, output.

   // Stage one: per-side source pick for every feed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_ana_ff <= '0;
         stage_dig_ff <= '0;
         stage_hp_ff <= '0;
         stage_valid_ff <= 1'b0;
      end else begin
         stage_valid_ff <= sample_valid;
         if (sample_valid) begin
            stage_ana_ff <= '{r: pick(ana_src_ff.r), l: pick(ana_src_ff.l)};
            stage_dig_ff <= '{r: pick(dig_src_ff.r), l: pick(dig_src_ff.l)};
            stage_hp_ff <= '{r: pick(hp_src_ff.r), l: pick(hp_src_ff.l)};
         end
      end
   end

   db_atten #(.W(SAMPLE_W)) u_ana_att (
      .pclk(pclk),
      .presetn(presetn),
      .att_db(ana_att_ff),
      .in_valid(stage_valid_ff),
      .in_s(stage_ana_ff),
      .out_s(ana_att_s),
      .out_valid(att_valid)
   );

   db_atten #(.W(SAMPLE_W)) u_dig_att (
      .pclk(pclk),
      .presetn(presetn),
      .att_db(dig_att_ff),
      .in_valid(stage_valid_ff),
      .in_s(stage_dig_ff),
      .out_s(dig_att_s),
      .out_valid()
   );

   // Headphones carry no attenuation here; a delay keeps them in step.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hp_dly_ff <= '0;
      end else if (stage_valid_ff) begin
         hp_dly_ff <= stage_hp_ff;
      end
   end

   // Output registers; line and tape share one attenuated signal.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_ff <= '0;
         tape_ff <= '0;
         dig_ff <= '0;
         hp_ff <= '0;
         out_valid_ff <= 1'b0;
      end else begin
         out_valid_ff <= att_valid;
         if (att_valid) begin
            line_ff <= ana_att_s;
            tape_ff <= ana_att_s;
            dig_ff <= dig_att_s;
            hp_ff <= hp_dly_ff;
         end
      end
   end

   // Channel status byte; copy management bits are never driven high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_byte_ff <= CS_RESET;
      end else begin
         cs_byte_ff <= CS_RESET;
         cs_byte_ff[CS_PRO_BIT] <= fmt_pro_ff;
         cs_byte_ff[CS_COPY_BIT] <= 1'b0;
      end
   end

   assign line_out = line_ff;
   assign tape_out = tape_ff;
   assign dig_out = dig_ff;
   assign hp_out = hp_ff;
   assign out_valid = out_valid_ff;
   assign cs_byte = cs_byte_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_in1_left;
      sample_valid && ana_src_ff.l == SRC_IN1;
   endsequence

   sequence s_full_scale_trk;
      sample_valid && dig_src_ff.r == SRC_SUM_TRK && !playing
         && trk_assigned.l == FS_POS && trk_assigned.r == FS_POS;
   endsequence

   a_input_pass: assert property (s_in1_left |=> stage_ana_ff.l == $past(inputs.l))
      else $error("input source not passed to analog left");
   a_track_rec: assert property (sample_valid && dig_src_ff.l == SRC_TRK_A && !playing
      |=> stage_dig_ff.l == $past(trk_assigned.l))
      else $error("track source not assigned audio while recording");
   a_sum_sat: assert property (s_full_scale_trk |=> stage_dig_ff.r == FS_POS)
      else $error("summed tracks wrapped instead of saturating");
   a_sum_inputs: assert property (sample_valid && hp_src_ff.l == SRC_SUM_IN
      && inputs.l == 24'sh000001 && inputs.r == 24'sh000002
      |=> stage_hp_ff.l == 24'sh000003)
      else $error("summed inputs wrong");
   a_zero_att: assert property (stage_valid_ff && ana_att_ff == '0 |=> ##1
      line_ff == $past(stage_ana_ff, 2))
      else $error("zero attenuation altered the analog bus");
   a_line_tape: assert property (line_ff == tape_ff)
      else $error("tape feed differs from line output");
   a_att_limit: assert property (ana_att_ff <= ATT_MAX_DB && dig_att_ff <= ATT_MAX_DB)
      else $error("attenuation beyond forty decibels");
   a_scms_clear: assert property (!cs_byte_ff[CS_COPY_BIT])
      else $error("copy management bit set");
   a_fmt_follow: assert property ($rose(fmt_pro_ff) |=> cs_byte_ff[CS_PRO_BIT])
      else $error("professional format not shown in channel status");
   a_mon_media: assert property (sample_valid && hp_src_ff.r == SRC_MON_B && recording
      && !playing && media_sel |=> stage_hp_ff.r == $past(media1_read.r))
      else $error("monitor not read from highlighted medium");
   a_out_latency: assert property (sample_valid |-> ##3 out_valid_ff)
      else $error("output not valid three cycles after sample");
endmodule
`default_nettype wire

// >>> test/bus_sink_model.sv
// Downstream sink model that captures every sample frame the router emits.
`default_nettype none
module bus_sink_model
   import bus_router_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Router outputs.
   input wire logic out_valid,
   input wire stereo_t line_out,
   input wire stereo_t tape_out,
   input wire stereo_t dig_out,
   input wire stereo_t hp_out,
   // Captured frames.
   output stereo_t cap_line,
   output stereo_t cap_tape,
   output stereo_t cap_dig,
   output stereo_t cap_hp,
   output logic [15:0] n_frames
);
   timeunit 1ns;
   timeprecision 1ps;
   // Frames are latched only on the strobe, so stale outputs between strobes go unseen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_line <= '0;
         cap_tape <= '0;
         cap_dig <= '0;
         cap_hp <= '0;
         n_frames <= 16'h0000;
      end else if (out_valid) begin
         cap_line <= line_out;
         cap_tape <= tape_out;
         cap_dig <= dig_out;
         cap_hp <= hp_out;
         n_frames <= n_frames + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// >>> test/audio_output_bus_router_tb_top.sv
// Self-checking bench for the output bus router.
`default_nettype none
module audio_output_bus_router_tb_top
   import bus_router_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, sample_valid, recording, playing, media_sel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, out_valid;
   logic [7:0] cs_byte;
   logic [15:0] n_frames;
   stereo_t inputs, trk_assigned, trk_played, media0_read, media1_read;
   stereo_t line_out, tape_out, dig_out, hp_out, cap_line, cap_tape, cap_dig, cap_hp;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   audio_output_bus_router audio_output_bus_router_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
      .inputs(inputs), .trk_assigned(trk_assigned), .trk_played(trk_played),
      .media0_read(media0_read), .media1_read(media1_read), .recording(recording),
      .playing(playing), .media_sel(media_sel), .line_out(line_out), .tape_out(tape_out),
      .dig_out(dig_out), .hp_out(hp_out), .out_valid(out_valid), .cs_byte(cs_byte));
   bus_sink_model bus_sink_model_inst (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
      .line_out(line_out), .tape_out(tape_out), .dig_out(dig_out), .hp_out(hp_out),
      .cap_line(cap_line), .cap_tape(cap_tape), .cap_dig(cap_dig), .cap_hp(cap_hp),
      .n_frames(n_frames));
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running clock at 125 MHz.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Cycle ceiling well above the roughly 1000 cycles the tests need.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer; request is held until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      // A slave that never answers counts as a mismatch.
      if (pready !== 1'b1) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic e_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk({err, rd}, {e_err, e});
   endtask
   // Sends one sample frame and waits, bounded, for the sink to capture the answer.
   task automatic push();
      logic [15:0] n0;
      int k;
      n0 = n_frames;
      @(posedge pclk);
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      k = 0;
      while (n_frames === n0 && k < 20) begin
         @(posedge pclk);
         k++;
      end
      // A lost frame counts as a mismatch.
      if (n_frames === n0) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, n_frames, n0 + 16'h0001);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic signed [23:0] sat(input logic signed [24:0] s);
      if (s > 25'sh07fffff) return 24'h7fffff;
      if (s < -25'sh0800000) return 24'h800000;
      return s[23:0];
   endfunction
   // Expected sample for a source code under the present transport state.
   function automatic logic signed [23:0] ex(input int c);
      logic signed [23:0] a, b;
      a = playing ? trk_played.l : trk_assigned.l;
      b = playing ? trk_played.r : trk_assigned.r;
      case (c)
         0: return inputs.l;
         1: return inputs.r;
         2: return a;
         3: return b;
         4: return sat({inputs.l[23], inputs.l} + {inputs.r[23], inputs.r});
         5: return sat({a[23], a} + {b[23], b});
         6: return playing ? a : recording ? (media_sel ? media1_read.l : media0_read.l) : 24'sh0;
         default: return playing ? b : recording ? (media_sel ? media1_read.r : media0_read.r)
                                                  : 24'sh0;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd_chk(ANA_SRC_OFS, 32'h10, 1'b0);
      rd_chk(DIG_SRC_OFS, 32'h10, 1'b0);
      rd_chk(HP_SRC_OFS, 32'h10, 1'b0);
      rd_chk(ANA_ATT_OFS, 32'h0, 1'b0);
      rd_chk(DIG_ATT_OFS, 32'h0, 1'b0);
      rd_chk(FORMAT_OFS, 32'h0, 1'b0);
      wr(8'h1c, 32'h1);
      rd_chk(8'h1c, 32'h0, 1'b1);
      chk(cs_byte, CS_RESET);
   endtask
   // Every source code on each bus, with left and right on different programs.
   task automatic t_sweep(input logic [7:0] a);
      for (int c = 0; c < 8; c++) begin
         wr(a, {25'h0, 3'(7 - c), 1'b0, 3'(c)});
         push();
         if (a == ANA_SRC_OFS) chk(cap_tape, {ex(7 - c), ex(c)});
         chk(a == ANA_SRC_OFS ? cap_line : a == DIG_SRC_OFS ? cap_dig : cap_hp,
             {ex(7 - c), ex(c)});
      end
   endtask
   task automatic t_indep();
      wr(ANA_SRC_OFS, 32'h23);
      wr(DIG_SRC_OFS, 32'h45);
      wr(HP_SRC_OFS, 32'h01);
      push();
      wr(DIG_SRC_OFS, 32'h67);
      push();
      chk(cap_line, {ex(2), ex(3)});
      chk(cap_hp, {ex(0), ex(1)});
      chk(cap_dig, {ex(6), ex(7)});
      rd_chk(ANA_SRC_OFS, 32'h23, 1'b0);
   endtask
   task automatic t_atten();
      wr(ANA_SRC_OFS, 32'h10);
      wr(DIG_SRC_OFS, 32'h10);
      wr(HP_SRC_OFS, 32'h10);
      wr(ANA_ATT_OFS, 32'h6);
      wr(DIG_ATT_OFS, 32'hc);
      push();
      chk(cap_line, {ex(1) >>> 1, ex(0) >>> 1});
      chk(cap_tape, {ex(1) >>> 1, ex(0) >>> 1});
      chk(cap_dig, {ex(1) >>> 2, ex(0) >>> 2});
      chk(cap_hp, {ex(1), ex(0)});
      wr(ANA_ATT_OFS, 32'h3f);
      rd_chk(ANA_ATT_OFS, {26'h0, ATT_MAX_DB}, 1'b0);
      wr(DIG_ATT_OFS, 32'h28);
      rd_chk(DIG_ATT_OFS, 32'h28, 1'b0);
      wr(ANA_ATT_OFS, 32'h0);
      wr(DIG_ATT_OFS, 32'h0);
      push();
      chk(cap_line, {ex(1), ex(0)});
      chk(cap_dig, {ex(1), ex(0)});
   endtask
   // Small sums must stay exact; full-scale tracks must clip rather than wrap.
   task automatic t_sums();
      inputs <= '{r: 24'h000002, l: 24'h000001};
      trk_assigned <= '{r: 24'h7fffff, l: 24'h7fffff};
      playing <= 1'b0;
      wr(HP_SRC_OFS, 32'h44);
      wr(DIG_SRC_OFS, 32'h50);
      push();
      chk(cap_hp, {24'h000003, 24'h000003});
      chk(cap_dig, {24'h7fffff, 24'h000001});
   endtask
   task automatic t_format();
      for (int f = 1; f >= 0; f--) begin
         wr(FORMAT_OFS, 32'(f));
         repeat (2) @(posedge pclk);
         chk({cs_byte[CS_COPY_BIT], cs_byte[CS_PRO_BIT]}, {1'b0, 1'(f)});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for three cycles, then each test in turn.
   initial begin
      {psel, penable, pwrite, sample_valid, recording, playing, media_sel} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      inputs = '{r: 24'h300000, l: 24'h600000};
      trk_assigned = '{r: 24'h000200, l: 24'h000100};
      trk_played = '{r: 24'h002000, l: 24'h001000};
      media0_read = '{r: 24'h020000, l: 24'h010000};
      media1_read = '{r: 24'h040000, l: 24'h030000};
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      $display("Test regs done");
      for (int s = 0; s < 4; s++) begin
         recording <= (s == 1 || s == 2);
         playing <= (s == 3);
         media_sel <= (s == 2);
         rd_chk(STATUS_OFS, {29'h0, s == 2, s == 3, s == 1 || s == 2}, 1'b0);
         t_sweep(ANA_SRC_OFS);
         t_sweep(DIG_SRC_OFS);
         t_sweep(HP_SRC_OFS);
      end
      $display("Test sweep done");
      t_indep();
      $display("Test indep done");
      t_atten();
      $display("Test atten done");
      t_sums();
      $display("Test sums done");
      t_format();
      $display("Test format done");
      end_of_test();
   end
endmodule
`default_nettype wire
